// *** common/pfs_chop_if.sv ***
// Link between the sequencer and its current-limiting chopper
interface pfs_chop_if;
	logic enable;
	logic drive;
	modport ctrl (output enable, input drive);
	modport gen  (input enable, output drive);
endinterface

// *** common/pfs_pkg.sv ***
// Constants, tables and types for the paper-feed stepper sequencer
package pfs_pkg;
	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned TICK_US      = 1;
	localparam int unsigned TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned PWM_HZ       = 15_000;
	localparam int unsigned PWM_PERIOD   = CLK_HZ / PWM_HZ;
	localparam int unsigned PWM_HIGH     = PWM_PERIOD / 2;
	localparam int unsigned DEBOUNCE_US  = 2000;
	localparam int unsigned SENSOR_US    = 50;
	localparam int unsigned ACCEL_STEPS  = 10;
	localparam int unsigned LOAD_DIV     = 4;
	localparam logic [2:0]  BLANK_LINES  = 3'h4;

	typedef logic [15:0] pfs_us_t;
	typedef logic [3:0]  pfs_phase_t;

	// Pattern bits are {ph1, ph2, ph3, ph4}, forward order
	localparam pfs_phase_t PHASE_TBL [4] = '{4'h9, 4'hA, 4'h6, 4'h5};

	localparam pfs_us_t ACCEL_US [ACCEL_STEPS] = '{
		16'(3952), 16'(2793), 16'(2283), 16'(1976), 16'(1768),
		16'(1613), 16'(1495), 16'(1395), 16'(1317), 16'(1250)};

	// Supply bands: below 4.5 V, 4.5-5.5 V, 5.5-6.5 V, above 6.5 V
	localparam int unsigned REG_PPS [4] = '{200, 300, 560, 800};
	localparam int unsigned BAND_V10 [4] = '{42, 45, 55, 65};
	localparam pfs_us_t REG_US [4] = '{
		16'(1_000_000 / REG_PPS[0]), 16'(1_000_000 / REG_PPS[1]),
		16'(1_000_000 / REG_PPS[2]), 16'(1_000_000 / REG_PPS[3])};
	localparam pfs_us_t LOAD_US [4] = '{
		16'(LOAD_DIV * REG_US[0]), 16'(LOAD_DIV * REG_US[1]),
		16'(LOAD_DIV * REG_US[2]), 16'(LOAD_DIV * REG_US[3])};
	// 72 / V^2 ms in microseconds, V in tenths of a volt
	localparam int unsigned PWM_DLY_NUM = 72 * 1000 * 100;
	localparam pfs_us_t PWM_START_US [4] = '{
		16'(PWM_DLY_NUM / (BAND_V10[0] * BAND_V10[0])),
		16'(PWM_DLY_NUM / (BAND_V10[1] * BAND_V10[1])),
		16'(PWM_DLY_NUM / (BAND_V10[2] * BAND_V10[2])),
		16'(PWM_DLY_NUM / (BAND_V10[3] * BAND_V10[3]))};

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAKE = 4'h2,
		ST_RUN  = 4'h4,
		ST_STOP = 4'h8
	} pfs_state_e;
endpackage

// *** design/pfs_pwm.sv ***
// Fixed-duty chopper that gates the phase drive on long steps
module pfs_pwm #(
	parameter int unsigned PERIOD = pfs_pkg::PWM_PERIOD,
	parameter int unsigned HIGH   = pfs_pkg::PWM_HIGH
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	pfs_chop_if.gen   chop
);
	import pfs_pkg::*;

	logic [15:0] cnt_ff;
	logic        drive_ff;
	logic [15:0] nxt_cnt;
	logic        nxt_drive;

	always_comb begin
		nxt_cnt   = 16'h0000;
		nxt_drive = 1'b1;
		if (chop.enable) begin
			if (cnt_ff < 16'(PERIOD - 1)) begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
			nxt_drive = (nxt_cnt < 16'(HIGH));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff   <= 16'h0000;
			drive_ff <= 1'b1;
		end else begin
			cnt_ff   <= nxt_cnt;
			drive_ff <= nxt_drive;
		end
	end

	assign chop.drive = drive_ff;
endmodule

// *** design/pfs_seq_top.sv ***
// Paper-feed stepper sequencer and head strobe interlock
module pfs_seq_top #(
	parameter int unsigned TICK_CYC       = pfs_pkg::TICK_CYC,
	parameter int unsigned PWM_PERIOD_CYC = pfs_pkg::PWM_PERIOD
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               step_req_i,
	input  wire logic               step_rev_i,
	output logic                    step_rdy_o,
	input  wire logic               load_mode_i,
	input  wire logic               head_busy_i,
	input  wire logic [1:0]         supply_band_i,
	input  wire logic               head_sw_closed_i,
	input  wire logic               paper_present_i,
	input  wire logic [5:0]         head_strobe_req_i,
	output logic      [5:0]         head_strobe_o,
	output pfs_pkg::pfs_phase_t     phase_o,
	output logic                    blank_line_o,
	output logic                    motor_busy_o,
	output logic                    ramp_active_o,
	output logic                    pwm_active_o
);
	import pfs_pkg::*;

	logic [15:0]  tick_cnt_ff;
	logic [15:0]  nxt_tick_cnt;
	logic         tick;
	logic         head_down;
	logic [2:0]   sens;
	logic         paper_ok;
	logic [1:0]   band;

	pfs_state_e   state_ff;
	pfs_state_e   nxt_state;
	logic [1:0]   pidx_ff;
	logic [1:0]   nxt_pidx;
	pfs_us_t      step_us_ff;
	pfs_us_t      nxt_step_us;
	logic [3:0]   ramp_idx_ff;
	logic [3:0]   nxt_ramp_idx;
	logic         ramp_on_ff;
	logic         nxt_ramp_on;
	logic         held_ff;
	logic         nxt_held;
	logic [2:0]   blank_ff;
	logic [2:0]   nxt_blank;
	logic         blank_step_ff;
	logic         nxt_blank_step;
	logic         pend_ff;
	logic         nxt_pend;
	logic         rev_ff;
	logic         nxt_rev;
	pfs_phase_t   phase_ff;
	pfs_phase_t   nxt_phase;
	logic [5:0]   strobe_ff;
	logic [5:0]   nxt_strobe;

	pfs_us_t      base_us;
	pfs_us_t      step_time;
	logic         step_done;
	logic         take;
	logic         advance;
	logic         adv_rev;
	logic [3:0]   adv_idx;
	logic         adv_on;

	pfs_chop_if chop ();

	// Microsecond tick; simulation may shorten it through TICK_CYC
	always_comb begin
		nxt_tick_cnt = tick_cnt_ff + 16'h0001;
		if (tick_cnt_ff >= 16'(TICK_CYC - 1)) begin
			nxt_tick_cnt = 16'h0000;
		end
	end
	assign tick = (tick_cnt_ff == 16'h0000);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_ff <= 16'h0000;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// Contact chatter would otherwise open the strobe gate briefly
	pfs_sync_filter #(
		.W      (1),
		.STABLE (DEBOUNCE_US / TICK_US)
	) u_head_filt (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_i (tick),
		.din_i  (head_sw_closed_i),
		.dout_o (head_down)
	);

	pfs_sync_filter #(
		.W      (3),
		.STABLE (SENSOR_US / TICK_US)
	) u_sens_filt (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_i (tick),
		.din_i  ({paper_present_i, supply_band_i}),
		.dout_o (sens)
	);
	assign paper_ok = sens[2];
	assign band     = sens[1:0];

	pfs_pwm #(
		.PERIOD (PWM_PERIOD_CYC),
		.HIGH   (PWM_PERIOD_CYC / 2)
	) u_pwm (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.chop  (chop.gen)
	);

	// Step timing for the present supply band
	always_comb begin
		base_us = load_mode_i ? LOAD_US[band] : REG_US[band];
		step_time = base_us;
		if (ramp_on_ff) begin
			step_time = ACCEL_US[ramp_idx_ff - 4'h1];
		end
	end
	assign step_done = (step_us_ff >= step_time);

	assign step_rdy_o = !pend_ff;
	assign take       = step_req_i && !pend_ff;

	// Next ramp entry for a step that starts now
	always_comb begin
		adv_idx = held_ff ? 4'h1 : ramp_idx_ff + 4'h1;
		adv_on  = (held_ff || ramp_on_ff) && !load_mode_i;
		if (adv_idx > 4'(ACCEL_STEPS)) begin
			adv_on = 1'b0;
		end else if (ACCEL_US[adv_idx - 4'h1] <= base_us) begin
			adv_on = 1'b0;
		end
	end

	// Blank lines after wake-up always feed forward
	assign adv_rev = (blank_ff != 3'h0) ? 1'b0 : rev_ff;

	always_comb begin
		nxt_state    = state_ff;
		nxt_pidx     = pidx_ff;
		nxt_step_us  = step_us_ff;
		nxt_ramp_idx = ramp_idx_ff;
		nxt_ramp_on  = ramp_on_ff;
		nxt_held     = held_ff;
		nxt_blank    = blank_ff;
		nxt_blank_step = blank_step_ff;
		nxt_pend     = pend_ff;
		nxt_rev      = rev_ff;
		advance      = 1'b0;
		if (take) begin
			nxt_pend = 1'b1;
			nxt_rev  = step_rev_i;
		end
		// Age keeps counting on a held step so chopping still starts
		if (tick && step_us_ff != 16'hFFFF) begin
			nxt_step_us = step_us_ff + 16'h0001;
		end
		case (state_ff)
			ST_IDLE: begin
				if (pend_ff) begin
					nxt_state   = ST_WAKE;
					nxt_step_us = 16'h0000;
					nxt_blank   = BLANK_LINES;
					nxt_held    = 1'b1;
					nxt_ramp_on = 1'b0;
				end
			end
			ST_WAKE: begin
				if (step_done) begin
					advance = 1'b1;
				end
			end
			ST_RUN: begin
				if (step_done) begin
					if (head_busy_i) begin
						nxt_held = 1'b1;
					end else if (pend_ff || blank_ff != 3'h0) begin
						advance = 1'b1;
					end else begin
						nxt_state   = ST_STOP;
						nxt_step_us = 16'h0000;
						nxt_ramp_on = 1'b0;
						nxt_blank_step = 1'b0;
					end
				end
			end
			ST_STOP: begin
				if (pend_ff) begin
					advance  = 1'b1;
					nxt_held = 1'b0;
				end else if (step_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (advance) begin
			nxt_state   = ST_RUN;
			nxt_step_us = 16'h0000;
			nxt_held    = 1'b0;
			nxt_ramp_on = adv_on && (state_ff != ST_STOP);
			nxt_ramp_idx = adv_on ? adv_idx : 4'h0;
			// The step now starting is blank while lines remain to feed
			nxt_blank_step = (blank_ff != 3'h0);
			if (adv_rev) begin
				nxt_pidx = pidx_ff - 2'h1;
			end else begin
				nxt_pidx = pidx_ff + 2'h1;
			end
			if (blank_ff != 3'h0) begin
				nxt_blank = blank_ff - 3'h1;
			end else begin
				nxt_pend = take;
			end
		end
	end

	// Chop once the step has outlasted the start delay for this band
	assign chop.enable = (state_ff != ST_IDLE) &&
		(step_us_ff >= PWM_START_US[band]);

	always_comb begin
		nxt_phase = 4'h0;
		if (nxt_state != ST_IDLE && chop.drive) begin
			nxt_phase = PHASE_TBL[nxt_pidx];
		end
		nxt_strobe = 6'h00;
		if (head_down && paper_ok) begin
			nxt_strobe = head_strobe_req_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff    <= ST_IDLE;
			pidx_ff     <= 2'h0;
			step_us_ff  <= 16'h0000;
			ramp_idx_ff <= 4'h0;
			ramp_on_ff  <= 1'b0;
			held_ff     <= 1'b0;
			blank_ff    <= 3'h0;
			blank_step_ff <= 1'b0;
			pend_ff     <= 1'b0;
			rev_ff      <= 1'b0;
			phase_ff    <= 4'h0;
			strobe_ff   <= 6'h00;
		end else begin
			state_ff    <= nxt_state;
			pidx_ff     <= nxt_pidx;
			step_us_ff  <= nxt_step_us;
			ramp_idx_ff <= nxt_ramp_idx;
			ramp_on_ff  <= nxt_ramp_on;
			held_ff     <= nxt_held;
			blank_ff    <= nxt_blank;
			blank_step_ff <= nxt_blank_step;
			pend_ff     <= nxt_pend;
			rev_ff      <= nxt_rev;
			phase_ff    <= nxt_phase;
			strobe_ff   <= nxt_strobe;
		end
	end

	assign phase_o       = phase_ff;
	assign head_strobe_o = strobe_ff;
	assign blank_line_o  = (state_ff == ST_WAKE) || blank_step_ff;
	assign motor_busy_o  = (state_ff != ST_IDLE);
	assign ramp_active_o = ramp_on_ff;
	assign pwm_active_o  = chop.enable;
endmodule

// *** design/pfs_sync_filter.sv ***
// Two-flop synchroniser with a stability filter counted in ticks
module pfs_sync_filter #(
	parameter int unsigned W      = 1,
	parameter int unsigned STABLE = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         tick_i,
	input  wire logic [W-1:0] din_i,
	output logic      [W-1:0] dout_o
);
	import pfs_pkg::*;

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] out_ff;
	logic [15:0]  cnt_ff;
	logic [W-1:0] nxt_out;
	logic [15:0]  nxt_cnt;

	always_comb begin
		nxt_out = out_ff;
		nxt_cnt = cnt_ff;
		if (s2_ff == out_ff) begin
			nxt_cnt = 16'h0000;
		end else if (tick_i) begin
			if (cnt_ff >= 16'(STABLE - 1)) begin
				nxt_out = s2_ff;
				nxt_cnt = 16'h0000;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			out_ff <= '0;
			cnt_ff <= 16'h0000;
		end else begin
			s1_ff  <= din_i;
			s2_ff  <= s1_ff;
			out_ff <= nxt_out;
			cnt_ff <= nxt_cnt;
		end
	end

	assign dout_o = out_ff;
endmodule

// *** verif/pfs_mech_model.sv ***
// Mechanism model: head switch with chatter, paper sensor, feed count
module pfs_mech_model import pfs_pkg::*; (
	input  wire logic            clk_i,
	input  wire logic            head_down_i,
	input  wire logic            paper_i,
	input  pfs_pkg::pfs_phase_t  phase_i,
	output logic                 head_sw_closed_o,
	output logic                 paper_present_o,
	output int                   lines_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] bounce_ff = 4'h0;
	pfs_phase_t last_ff   = 4'h0;
	initial {head_sw_closed_o, paper_present_o, lines_o} = '0;
	always @(posedge clk_i) begin
		bounce_ff <= head_down_i ? {bounce_ff[2:0], 1'b1} : 4'h0;
		// Leaf contact bounces once before it settles closed
		head_sw_closed_o <= head_down_i & (bounce_ff[3] |
			bounce_ff[1] & ~bounce_ff[2]);
		paper_present_o <= paper_i;
		if (phase_i != 4'h0)
			last_ff <= phase_i;
		for (int k = 0; k < 4; k++)
			if (last_ff == PHASE_TBL[k] && phase_i == PHASE_TBL[(k + 1) % 4])
				lines_o <= lines_o + 1;
	end
endmodule

// *** verif/pfs_seq_props.sv ***
// Port-level assertions for the paper-feed stepper sequencer
module pfs_seq_props #(
	parameter int unsigned TICK_CYC       = 200,
	parameter int unsigned PWM_PERIOD_CYC = 13333
) (
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                step_req_i,
	input wire logic                step_rdy_o,
	input wire logic                head_sw_closed_i,
	input wire logic                paper_present_i,
	input wire logic [5:0]          head_strobe_o,
	input wire pfs_pkg::pfs_phase_t phase_o,
	input wire logic                blank_line_o,
	input wire logic                motor_busy_o,
	input wire logic                pwm_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Run lengths saturate so the filters get their full time first
	localparam int HEAD_CYC = 2010 * TICK_CYC;
	localparam int DRY_CYC  = 60 * TICK_CYC;
	localparam int PWM_MIN  = 1703 * TICK_CYC - 2;
	localparam int HALF     = PWM_PERIOD_CYC / 2 + 2;
	int         up_ff, dry_ff, age_ff, nxt_up, nxt_dry, nxt_age;
	int         low_ff, nxt_low;
	logic [3:0] ph_ff;
	always_comb begin
		nxt_up  = head_sw_closed_i ? 0 : up_ff + int'(up_ff < HEAD_CYC);
		nxt_dry = paper_present_i ? 0 : dry_ff + int'(dry_ff < DRY_CYC);
		nxt_age = (phase_o != ph_ff && !pwm_active_o) ? 0
			: age_ff + int'(age_ff < PWM_MIN);
		// Length of the present gap in the chopped drive
		nxt_low = (pwm_active_o && phase_o == 4'h0)
			? low_ff + int'(low_ff <= HALF) : 0;
	end
	always_ff @(posedge clk_i) begin
		up_ff  <= rst_i ? 0 : nxt_up;
		dry_ff <= rst_i ? 0 : nxt_dry;
		age_ff <= rst_i ? 0 : nxt_age;
		low_ff <= rst_i ? 0 : nxt_low;
		ph_ff  <= phase_o;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_idle_no_excite: assert property (
		!motor_busy_o [*3] |-> phase_o == 4'h0) else $error("idle excite");
	a_adjacent_step: assert property (
		$changed(phase_o) && phase_o != 4'h0 && $past(phase_o) != 4'h0
		|-> $countones(phase_o ^ $past(phase_o)) == 2) else $error("jump");
	a_head_up_block: assert property (
		up_ff >= HEAD_CYC |-> head_strobe_o == 6'h0) else $error("head up");
	a_no_paper_block: assert property (
		dry_ff >= DRY_CYC |-> head_strobe_o == 6'h0) else $error("no paper");
	a_rdy_answer: assert property (
		step_req_i && step_rdy_o |=> !step_rdy_o) else $error("rdy held");
	a_wake_blank: assert property (
		$rose(motor_busy_o) |-> blank_line_o) else $error("no wake");
	a_pwm_delay: assert property (
		$rose(pwm_active_o) |-> age_ff >= PWM_MIN) else $error("pwm early");
	a_chop_rate: assert property (
		low_ff <= HALF) else $error("chop slow");
endmodule
bind pfs_seq_top pfs_seq_props #(
	.TICK_CYC(TICK_CYC), .PWM_PERIOD_CYC(PWM_PERIOD_CYC)
) i_pfs_seq_props (
	.clk_i, .rst_i, .step_req_i, .step_rdy_o, .head_sw_closed_i,
	.paper_present_i, .head_strobe_o, .phase_o, .blank_line_o,
	.motor_busy_o, .pwm_active_o
);

// *** verif/test_paper_feed_stepper_sequencer.sv ***
// Self-checking bench for the paper-feed stepper sequencer
module test_paper_feed_stepper_sequencer import pfs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, rst = 1'b1, req = 1'b0, rev = 1'b0;
	logic       hbusy = 1'b0, head_dn = 1'b1, paper = 1'b1, saw_pwm = 1'b0;
	logic       rdy, sw, pp, blank, busy, ramp, pwm;
	logic       load = 1'b0;
	logic [5:0] sreq = 6'h0;
	localparam int TCK      = 2;
	localparam int LOAD_CYC =
		TCK * (int'(ACCEL_US[0]) + int'(LOAD_US[3]));
	logic [5:0] strobe;
	logic [3:0] phase;
	logic [3:0] cur = 4'h0;
	int         lines;
	int         mismatches = 0;
	int         compares = 0;

	always #2.5 clk = ~clk;

	pfs_seq_top #(.TICK_CYC(TCK), .PWM_PERIOD_CYC(20)) i_pfs_seq_top (
		.clk_i(clk), .rst_i(rst), .step_req_i(req), .step_rev_i(rev),
		.step_rdy_o(rdy), .load_mode_i(load), .head_busy_i(hbusy),
		.supply_band_i(2'h3), .head_sw_closed_i(sw),
		.paper_present_i(pp), .head_strobe_req_i(sreq),
		.head_strobe_o(strobe), .phase_o(phase), .blank_line_o(blank),
		.motor_busy_o(busy), .ramp_active_o(ramp), .pwm_active_o(pwm));
	pfs_mech_model i_pfs_mech_model (
		.clk_i(clk), .head_down_i(head_dn), .paper_i(paper),
		.phase_i(phase), .head_sw_closed_o(sw), .paper_present_o(pp),
		.lines_o(lines));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One falling edge; a wait past its bound ends the run
	task automatic tick(inout int n, input int lim);
		@(negedge clk);
		saw_pwm |= pwm;
		if (++n > lim) begin
			chk(8'h0, 8'h1);
			report_and_stop();
		end
	endtask

	function automatic logic [3:0] adv(input logic [3:0] p, input int d);
		for (int k = 0; k < 4; k++)
			if (PHASE_TBL[k] == p)
				return PHASE_TBL[(k + d) % 4];
		return 4'h0;
	endfunction

	task automatic request(input logic r);
		int n;
		n = 0;
		req = 1'b1;
		rev = r;
		while (rdy !== 1'b1)
			tick(n, 40000);
		@(negedge clk);
		req = 1'b0;
	endtask

	// Next excited pattern; chopper gaps are skipped
	task automatic wait_step(input logic b, input int d);
		int n;
		n = 0;
		while (phase === 4'h0 || phase === cur)
			tick(n, 30000);
		if (d > 0)
			chk(8'(phase), 8'(adv(cur, d)));
		chk(8'(blank), 8'(b));
		cur = phase;
	endtask

	task automatic t_strobe();
		sreq = 6'h2D;
		@(negedge clk);
		chk(8'(strobe), 8'h2D);
		head_dn = 1'b0;
		repeat (4200) @(negedge clk);
		chk(8'(strobe), 8'h0);
		head_dn = 1'b1;
		paper = 1'b0;
		repeat (4300) @(negedge clk);
		chk(8'(strobe), 8'h0);
		paper = 1'b1;
		repeat (150) @(negedge clk);
		chk(8'(strobe), 8'h2D);
		sreq = 6'h0;
	endtask

	task automatic t_start();
		int l0;
		l0 = lines;
		request(1'b0);
		wait_step(1'b1, 0);
		saw_pwm = 1'b0;
		for (int i = 0; i < 4; i++)
			wait_step(1'b1, 1);
		chk(8'(saw_pwm), 8'h1);
		wait_step(1'b0, 1);
		chk(8'(ramp), 8'h1);
		// The feed count follows the phase change by one edge
		@(negedge clk);
		chk(8'(lines - l0), 8'h5);
	endtask

	task automatic t_restart();
		int n;
		n = 0;
		// Lands inside the stop step that follows the last real step
		repeat (4785) @(negedge clk);
		chk(8'(phase), 8'(cur));
		request(1'b1);
		wait_step(1'b0, 3);
		hbusy = 1'b1;
		request(1'b0);
		repeat (6000) begin
			@(negedge clk);
			if (phase !== cur && phase !== 4'h0)
				chk(8'(phase), 8'(cur));
		end
		chk(8'(pwm), 8'h1);
		hbusy = 1'b0;
		wait_step(1'b0, 1);
		chk(8'(ramp), 8'h1);
		// Loading speed stretches the stop step after this ramp step
		load = 1'b1;
		while (busy === 1'b1) begin
			tick(n, 30000);
			if (phase !== cur && phase !== 4'h0)
				chk(8'(phase), 8'(cur));
		end
		chk(8'(n >= LOAD_CYC - 8 && n <= LOAD_CYC + 8), 8'h1);
		load = 1'b0;
		repeat (3) @(negedge clk);
		chk(8'(phase), 8'h0);
	endtask

	initial begin
		repeat (2) @(negedge clk);
		chk(8'(phase), 8'h0);
		chk(8'(rdy), 8'h1);
		rst = 1'b0;
		repeat (4300) @(negedge clk);
		t_strobe();
		t_start();
		t_restart();
		report_and_stop();
	end
endmodule
